// file: include/gcc_pkg.sv
// Purpose: Shared constants for the general configuration and clock output block
// Assumes: APB byte address is four times the register index
// Notes:   Field positions are bit numbers inside 8-bit registers
package gcc_pkg;

  // ----------------------------------------------------------------
  // Register indices and bus geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_WIDTH    = 16;
  localparam int unsigned REG_WIDTH     = 8;
  localparam logic [13:0] IDX_GEN_CFG   = 14'h2002;
  localparam logic [13:0] IDX_DIV_HIGH  = 14'h2003;
  localparam logic [13:0] IDX_DIV_LOW   = 14'h2004;
  localparam logic [13:0] IDX_AUDIO_CFG = 14'h2005;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_GEN_CFG   = 8'hb0;
  localparam logic [7:0] RST_DIV_HIGH  = 8'h00;
  localparam logic [7:0] RST_DIV_LOW   = 8'h00;
  localparam logic [7:0] RST_AUDIO_CFG = 8'h00;

  // ----------------------------------------------------------------
  // General configuration fields
  // ----------------------------------------------------------------
  localparam int unsigned POS_POWER_UP    = 7;
  localparam int unsigned POS_RATE_SEL    = 6;
  localparam int unsigned POS_CLKOUT_EN   = 5;
  localparam int unsigned POS_CLKOUT_SRC  = 4;
  localparam int unsigned POS_BUS_OD_SEL  = 3;
  localparam int unsigned POS_DIV_TOP_MSB = 2;
  localparam int unsigned DIV_WIDTH       = 19;

  // ----------------------------------------------------------------
  // Serial audio signal fields
  // ----------------------------------------------------------------
  localparam int unsigned POS_AUDIO_OD_SEL = 7;

  // ----------------------------------------------------------------
  // Bus clock edge counting
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    GCC_EDGE_IDLE  = 2'b00,
    GCC_EDGE_FIRST = 2'b01
  } gcc_edge_t;

endpackage

// file: rtl/gcc_clock_divider.sv
// Purpose: Divides the running DSP clock by a programmable factor
// Assumes: run is low while the DSP clock is stopped
// Notes:   Output toggles every factor+1 cycles; restart clears the phase
`timescale 1ns/1ps
module gcc_clock_divider #(
  parameter int unsigned WIDTH = 19
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Control
  input  wire logic             run,
  input  wire logic             restart,
  input  wire logic [WIDTH-1:0] factor,
  // Divided clock level
  output logic                  divClk
);

  initial begin
    if (WIDTH < 1 || WIDTH > 31) begin
      $error("gcc_clock_divider: WIDTH out of range");
    end
  end

  logic [WIDTH-1:0] count;

  // Cleared to its initial state on restart or reset; frozen at its current count while run is low
  always_ff @(posedge clk) begin
    if (rst || restart) begin
      count  <= '0;
      divClk <= 1'b0;
    end else if (run) begin
      if (count >= factor) begin
        count  <= '0;
        divClk <= ~divClk;
      end else begin
        count <= count + 1'b1;
      end
    end
  end

endmodule

// file: rtl/gcc_general_config.sv
// Purpose: General configuration, DSP clock power control and clock output pin
// Assumes: 10 MHz clk; pad inputs pass two flops; APB slave with no wait states
// Notes:   fixedClock768 is a level from on-chip logic clocked by clk
//
// The APB slave port is this design's own decision.
`timescale 1ns/1ps

// How it works
// [R1] Clearing power-up stops the DSP clock; a DSP interrupt restarts it.
// [R2] Power-up bit resets to one, DSP clock running.
// [R3] Rate select zero: bus data clock is twice the bit rate.
// [R4] Rate select one: bus data clock equals the bit rate.
// [R5] Clock output enable resets set; cleared, pin floats and divider idles.
// [R6] Power-up and clock enable both zero: every output pin floats.
// [R7] Source zero: DSP clock feeds the clock output divider.
// [R8] Source one, the reset value: fixed 7.68 MHz clock on the output.
// [R9] Bus open-drain bit resets zero (open drain); one gives push-pull.
// [R10] Divisor is three high config bits plus sixteen baud register bits.
// [R11] Audio open-drain bit resets zero, audio lines push-pull.
// [R12] Output is DSP clock divided by 2*(divisor+1), restarted on rewrite.
module gcc_general_config #(
  parameter int unsigned DIV_BITS = gcc_pkg::DIV_WIDTH
) (
  // Clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst,
  // APB slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [gcc_pkg::ADDR_WIDTH-1:0]  paddr,
  input  wire logic [31:0]                     pwdata,
  input  wire logic [3:0]                      pstrb,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // DSP clock control
  input  wire logic                            dspInterrupt,
  output logic                                 dspClockRun,
  // Bus data clock
  input  wire logic                            busDataClockInput,
  output logic                                 busBitStrobe,
  // Clock output
  input  wire logic                            fixedClock768,
  output logic                                 clockOutputPin,
  output logic                                 clockOutputPinOe_n,
  // Bus data lines, core side and pad side
  input  wire logic                            downstreamDataOut,
  input  wire logic                            downstreamDriveReq,
  input  wire logic                            upstreamDataOut,
  input  wire logic                            upstreamDriveReq,
  output logic                                 downstreamDataLine,
  output logic                                 downstreamDataLineOe_n,
  output logic                                 upstreamDataLine,
  output logic                                 upstreamDataLineOe_n,
  // Audio lines, core side and pad side
  input  wire logic                            audioReceiveOut,
  input  wire logic                            audioReceiveDriveReq,
  input  wire logic                            audioTransmitOut,
  input  wire logic                            audioTransmitDriveReq,
  output logic                                 audioReceiveLine,
  output logic                                 audioReceiveLineOe_n,
  output logic                                 audioTransmitLine,
  output logic                                 audioTransmitLineOe_n,
  // Status
  output logic                                 globalHighZ
);

  initial begin
    if (DIV_BITS != gcc_pkg::DIV_WIDTH) begin
      $error("gcc_general_config: divisor width is fixed by the register layout");
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] generalConfiguration;
  logic [7:0] clockOutDividerHigh;
  logic [7:0] clockOutDividerLow;
  logic [7:0] serialAudioSignalConfig;

  logic powerUpBit;
  logic busClockRateSelect;
  logic clockOutputEnable;
  logic clockOutputSource;
  logic busOpenDrainSelect;
  logic audioOpenDrainSelect;
  logic [DIV_BITS-1:0] clockOutputDivisor;

  assign powerUpBit           = generalConfiguration[gcc_pkg::POS_POWER_UP];
  assign busClockRateSelect   = generalConfiguration[gcc_pkg::POS_RATE_SEL];
  assign clockOutputEnable    = generalConfiguration[gcc_pkg::POS_CLKOUT_EN];
  assign clockOutputSource    = generalConfiguration[gcc_pkg::POS_CLKOUT_SRC];
  assign busOpenDrainSelect   = generalConfiguration[gcc_pkg::POS_BUS_OD_SEL];
  assign audioOpenDrainSelect = serialAudioSignalConfig[gcc_pkg::POS_AUDIO_OD_SEL];
  assign clockOutputDivisor   = {generalConfiguration[gcc_pkg::POS_DIV_TOP_MSB:0],
                                 clockOutDividerHigh, clockOutDividerLow}; // [R10]

  // ----------------------------------------------------------------
  // Pad input synchronisers
  // ----------------------------------------------------------------
  logic [1:0] intSync;
  logic [1:0] dclSync;

  always_ff @(posedge clk) begin
    if (rst) begin
      intSync <= 2'b00;
      dclSync <= 2'b00;
    end else begin
      intSync <= {intSync[0], dspInterrupt};
      dclSync <= {dclSync[0], busDataClockInput};
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [13:0] regIndex;
  logic        hitGen;
  logic        hitHigh;
  logic        hitLow;
  logic        hitAudio;
  logic        mapped;
  logic        setupPhase;
  logic        writeNow;
  logic        errFlag;

  assign regIndex   = paddr[gcc_pkg::ADDR_WIDTH-1:2];
  assign hitGen     = (regIndex == gcc_pkg::IDX_GEN_CFG);
  assign hitHigh    = (regIndex == gcc_pkg::IDX_DIV_HIGH);
  assign hitLow     = (regIndex == gcc_pkg::IDX_DIV_LOW);
  assign hitAudio   = (regIndex == gcc_pkg::IDX_AUDIO_CFG);
  assign mapped     = hitGen | hitHigh | hitLow | hitAudio;
  assign setupPhase = psel & ~penable;
  assign writeNow   = psel & penable & pwrite & mapped & pstrb[0];
  assign pready     = 1'b1;
  assign pslverr    = psel & penable & errFlag;

  // Read data and error are captured in setup so they come from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      prdata  <= 32'h0000_0000;
      errFlag <= 1'b0;
    end else if (setupPhase) begin
      errFlag <= ~mapped;
      if (pwrite || !mapped) begin
        prdata <= 32'h0000_0000;
      end else if (hitGen) begin
        prdata <= {24'h00_0000, generalConfiguration};
      end else if (hitHigh) begin
        prdata <= {24'h00_0000, clockOutDividerHigh};
      end else if (hitLow) begin
        prdata <= {24'h00_0000, clockOutDividerLow};
      end else begin
        prdata <= {24'h00_0000, serialAudioSignalConfig};
      end
    end
  end

  // ----------------------------------------------------------------
  // General configuration and DSP clock control
  // ----------------------------------------------------------------
  // An interrupt in the same cycle as a power-down write wins
  always_ff @(posedge clk) begin
    if (rst) begin
      generalConfiguration <= gcc_pkg::RST_GEN_CFG; // [R2] [R5] [R8] [R9]
    end else begin
      if (writeNow && hitGen) begin
        generalConfiguration <= pwdata[7:0];
      end
      if (intSync[1]) begin
        generalConfiguration[gcc_pkg::POS_POWER_UP] <= 1'b1; // [R1]
      end
    end
  end

  assign dspClockRun = powerUpBit; // [R1]

  always_ff @(posedge clk) begin
    if (rst) begin
      clockOutDividerHigh     <= gcc_pkg::RST_DIV_HIGH;
      clockOutDividerLow      <= gcc_pkg::RST_DIV_LOW;
      serialAudioSignalConfig <= gcc_pkg::RST_AUDIO_CFG; // [R11]
    end else if (writeNow) begin
      if (hitHigh) begin
        clockOutDividerHigh <= pwdata[7:0];
      end
      if (hitLow) begin
        clockOutDividerLow <= pwdata[7:0];
      end
      if (hitAudio) begin
        serialAudioSignalConfig <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus data clock to bit rate
  // ----------------------------------------------------------------
  logic              dclLast;
  logic              dclRise;
  gcc_pkg::gcc_edge_t edgePhase;

  assign dclRise = dclSync[1] & ~dclLast;

  always_ff @(posedge clk) begin
    if (rst) begin
      dclLast      <= 1'b0;
      edgePhase    <= gcc_pkg::GCC_EDGE_IDLE;
      busBitStrobe <= 1'b0;
    end else begin
      dclLast      <= dclSync[1];
      busBitStrobe <= 1'b0;
      if (dclRise) begin
        if (busClockRateSelect) begin
          busBitStrobe <= 1'b1; // [R4]
          edgePhase    <= gcc_pkg::GCC_EDGE_IDLE;
        end else begin
          case (edgePhase) // [R3]
            gcc_pkg::GCC_EDGE_IDLE: begin
              edgePhase <= gcc_pkg::GCC_EDGE_FIRST;
            end
            gcc_pkg::GCC_EDGE_FIRST: begin
              edgePhase    <= gcc_pkg::GCC_EDGE_IDLE;
              busBitStrobe <= 1'b1;
            end
            default: begin
              edgePhase <= gcc_pkg::GCC_EDGE_IDLE;
            end
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock output generation
  // ----------------------------------------------------------------
  logic divRestart;
  logic divRun;
  logic divClk;

  // A rewritten factor takes effect from a clean phase
  assign divRestart = ~clockOutputEnable
                    | (writeNow & (hitGen | hitHigh | hitLow)); // [R5] [R12]
  assign divRun     = dspClockRun & ~clockOutputSource; // [R7]

  gcc_clock_divider #(
    .WIDTH (DIV_BITS)
  ) u_divider (
    .clk     (clk),
    .rst     (rst),
    .run     (divRun),
    .restart (divRestart),
    .factor  (clockOutputDivisor),
    .divClk  (divClk)
  );

  assign globalHighZ = ~powerUpBit & ~clockOutputEnable; // [R6]

  // ----------------------------------------------------------------
  // Pad drivers
  // ----------------------------------------------------------------
  // Open drain drives only the low level; a high floats to the pull-up
  always_ff @(posedge clk) begin
    if (rst) begin
      clockOutputPin         <= 1'b0;
      clockOutputPinOe_n     <= 1'b1;
      downstreamDataLine     <= 1'b0;
      downstreamDataLineOe_n <= 1'b1;
      upstreamDataLine       <= 1'b0;
      upstreamDataLineOe_n   <= 1'b1;
      audioReceiveLine       <= 1'b0;
      audioReceiveLineOe_n   <= 1'b1;
      audioTransmitLine      <= 1'b0;
      audioTransmitLineOe_n  <= 1'b1;
    end else begin
      clockOutputPin     <= clockOutputSource ? fixedClock768 : divClk; // [R7] [R8] [R12]
      clockOutputPinOe_n <= ~clockOutputEnable | globalHighZ; // [R5] [R6]

      downstreamDataLine     <= busOpenDrainSelect & downstreamDataOut;
      downstreamDataLineOe_n <= globalHighZ | ~downstreamDriveReq
                              | (~busOpenDrainSelect & downstreamDataOut); // [R9] [R6]
      upstreamDataLine       <= busOpenDrainSelect & upstreamDataOut;
      upstreamDataLineOe_n   <= globalHighZ | ~upstreamDriveReq
                              | (~busOpenDrainSelect & upstreamDataOut); // [R9] [R6]

      audioReceiveLine       <= ~audioOpenDrainSelect & audioReceiveOut;
      audioReceiveLineOe_n   <= globalHighZ | ~audioReceiveDriveReq
                              | (audioOpenDrainSelect & audioReceiveOut); // [R11] [R6]
      audioTransmitLine      <= ~audioOpenDrainSelect & audioTransmitOut;
      audioTransmitLineOe_n  <= globalHighZ | ~audioTransmitDriveReq
                              | (audioOpenDrainSelect & audioTransmitOut); // [R11] [R6]
    end
  end

endmodule

// file: test/gcc_general_config_assertions.sv
// Purpose: Port assertions for the general config block
// Assumes: Config shadow tracks completed APB writes
// Notes:   Bit 7 is left out, the interrupt may set it
`timescale 1ns/1ps
module gcc_general_config_checker (
  // Clock, reset and APB
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  // Core side and pads
  input wire logic        dspInterrupt,
  input wire logic        dspClockRun,
  input wire logic        busDataClockInput,
  input wire logic        busBitStrobe,
  input wire logic        fixedClock768,
  input wire logic        clockOutputPin,
  input wire logic        clockOutputPinOe_n,
  input wire logic        downstreamDataOut,
  input wire logic        downstreamDriveReq,
  input wire logic        downstreamDataLine,
  input wire logic        downstreamDataLineOe_n,
  input wire logic        audioTransmitOut,
  input wire logic        audioTransmitDriveReq,
  input wire logic        audioTransmitLine,
  input wire logic        audioTransmitLineOe_n,
  input wire logic        globalHighZ
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // Shadow of written control bits
  // ------------------------------------------------------------
  logic [6:0] cfg;
  logic       aud;
  logic       wr;
  assign wr = psel && penable && pwrite && pready && pstrb[0];
  always_ff @(posedge clk) begin
    if (rst) cfg <= 7'h30;
    else if (wr && paddr == 16'h8008) cfg <= pwdata[6:0];
  end
  always_ff @(posedge clk) begin
    if (rst) aud <= 1'b0;
    else if (wr && paddr == 16'h8014) aud <= pwdata[7];
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  chk_irq_restart: assert property (
    dspInterrupt [*3] |-> ##[0:1] dspClockRun) else $error("run not restored");
  chk_fixed_pass: assert property (
    !$past(rst) && $past(cfg[4]) |-> clockOutputPin == $past(fixedClock768))
    else $error("fixed clock not passed");
  chk_oe_off: assert property (
    !$past(rst) && !$past(cfg[5]) |-> clockOutputPinOe_n) else $error("pin driven");
  chk_oe_on: assert property (
    !$past(rst) && $past(cfg[5]) && !$past(globalHighZ) |-> !clockOutputPinOe_n)
    else $error("pin not driven");
  chk_highz_pins: assert property (
    globalHighZ |=> clockOutputPinOe_n && downstreamDataLineOe_n && audioTransmitLineOe_n)
    else $error("pin driven in high z");
  chk_highz_cause: assert property (
    globalHighZ == (!dspClockRun && !cfg[5])) else $error("high z cause");
  chk_bus_od: assert property (
    !$past(rst) && !$past(cfg[3]) && !$past(globalHighZ) |-> !downstreamDataLine &&
    downstreamDataLineOe_n == !($past(downstreamDriveReq) && !$past(downstreamDataOut)))
    else $error("bus line not open drain");
  chk_bus_pp: assert property (
    !$past(rst) && $past(cfg[3]) && !$past(globalHighZ) |->
    downstreamDataLine == $past(downstreamDataOut) &&
    downstreamDataLineOe_n == !$past(downstreamDriveReq)) else $error("bus not push-pull");
  chk_audio_pp: assert property (
    !$past(rst) && !$past(aud) && !$past(globalHighZ) |->
    audioTransmitLine == $past(audioTransmitOut) &&
    audioTransmitLineOe_n == !$past(audioTransmitDriveReq)) else $error("audio not push-pull");
  chk_rate_equal: assert property (
    cfg[6] && $rose(busDataClockInput) |-> ##[2:4] busBitStrobe) else $error("strobe missed");
  chk_rate_twice: assert property (
    !cfg[6] && busBitStrobe |=> (!busBitStrobe || cfg[6]) [*8]) else $error("strobe early");
endmodule

bind gcc_general_config gcc_general_config_checker chk (.clk, .rst, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pstrb, .pready, .dspInterrupt, .dspClockRun,
  .busDataClockInput, .busBitStrobe, .fixedClock768, .clockOutputPin, .clockOutputPinOe_n,
  .downstreamDataOut, .downstreamDriveReq, .downstreamDataLine, .downstreamDataLineOe_n,
  .audioTransmitOut, .audioTransmitDriveReq, .audioTransmitLine, .audioTransmitLineOe_n,
  .globalHighZ);

// file: test/gcc_peripheral_model.sv
// Purpose: Peripheral clocked from the clock output pin
// Assumes: Pin means nothing while its enable is high
// Notes:   Measures the pin half period in clk cycles
`timescale 1ns/1ps
module gcc_peripheral_model (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Clock output pin
  input  wire logic pin,
  input  wire logic pinOe_n,
  // Measurements
  output int        halfPeriod,
  output int        pinEdges
);
  // ------------------------------------------------------------
  // Half period counter
  // ------------------------------------------------------------
  logic lastPin;
  int   run;
  always_ff @(posedge clk) begin
    if (rst || pinOe_n) begin
      run      <= 0;
      pinEdges <= 0;
    end else if (pin != lastPin) begin
      halfPeriod <= run + 1;
      run        <= 0;
      pinEdges   <= pinEdges + 1;
    end else begin
      run <= run + 1;
    end
  end
  always_ff @(posedge clk) lastPin <= pin;
endmodule

// file: test/test_general_config_clock_output.sv
// Purpose: Self-checking bench of the general config block
// Assumes: Pads run from a free LFSR stream, APB from one task
// Notes:   Register model is a plain array of bytes
`timescale 1ns/1ps
module test_general_config_clock_output;
  // ------------------------------------------------------------
  // Stimulus, model and counters
  // ------------------------------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, dspInterrupt = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic [3:0]  pstrb = 4'h0, lineOe_n, padLine;
  logic        pready, pslverr, dspClockRun, busBitStrobe, clkPin, clkOe_n, highZ, lastErr;
  logic [8:0]  pad = 9'h000;
  logic [2:0]  busCnt = 3'h0;
  logic [31:0] padSeed = 32'h00014818, seed = 32'h00014818;
  int          mdl [4] = '{8'hb0, 8'h00, 8'h00, 8'h00};
  int          fail_count = 0, comparisons = 0, strobes = 0, halfPeriod, pinEdges;
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    padSeed <= lfsrNext(padSeed);
    pad     <= padSeed[8:0];
    busCnt  <= busCnt + 3'h1;
    if (busBitStrobe === 1'b1) strobes <= strobes + 1;
  end
  gcc_general_config dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .dspInterrupt, .dspClockRun, .busDataClockInput(busCnt[2]),
    .busBitStrobe, .fixedClock768(pad[8]), .clockOutputPin(clkPin),
    .clockOutputPinOe_n(clkOe_n), .downstreamDataOut(pad[0]), .downstreamDriveReq(pad[1]),
    .upstreamDataOut(pad[2]), .upstreamDriveReq(pad[3]), .downstreamDataLine(padLine[0]),
    .downstreamDataLineOe_n(lineOe_n[0]), .upstreamDataLine(padLine[1]),
    .upstreamDataLineOe_n(lineOe_n[1]), .audioReceiveOut(pad[4]), .audioReceiveDriveReq(pad[5]),
    .audioTransmitOut(pad[6]), .audioTransmitDriveReq(pad[7]), .audioReceiveLine(padLine[2]),
    .audioReceiveLineOe_n(lineOe_n[2]), .audioTransmitLine(padLine[3]),
    .audioTransmitLineOe_n(lineOe_n[3]), .globalHighZ(highZ));
  gcc_peripheral_model peer (.clk, .rst, .pin(clkPin), .pinOe_n(clkOe_n), .halfPeriod,
    .pinEdges);
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [15:0] a, input logic [7:0] d,
                     input logic [3:0] s);
    int n;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= {24'h0, d};
    pstrb  <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      fail_count++;
      tally_and_finish();
    end
    rdata   = prdata;
    lastErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic regWrite(input int i, input logic [7:0] d);
    apb(1'b1, 16'h8008 + 16'(4 * i), d, 4'h1);
    mdl[i] = d;
  endtask
  task automatic regRead(input int i);
    apb(1'b0, 16'h8008 + 16'(4 * i), 8'h00, 4'h0);
  endtask
  task automatic irqPulse();
    dspInterrupt <= 1'b1;
    repeat (5) @(posedge clk);
    dspInterrupt <= 1'b0;
    mdl[0] = mdl[0] | 8'h80;
    check("run on", dspClockRun, 1'b1);
    regRead(0);
    check("power up", rdata, mdl[0]);
  endtask
  // Pads registered once: lines one edge after the pad sample
  task automatic lineCheck();
    logic [8:0] p;
    logic       bo, ao;
    logic [3:0] eb, ea;
    bo = mdl[0][3];
    ao = mdl[3][7];
    @(posedge clk);
    p = pad;
    @(posedge clk);
    eb = bo ? {p[2], p[0], !p[3], !p[1]} : {2'b00, !(p[3] & !p[2]), !(p[1] & !p[0])};
    ea = ao ? {2'b00, !(p[7] & !p[6]), !(p[5] & !p[4])} : {p[6], p[4], !p[7], !p[5]};
    check("bus lines", {padLine[1:0], lineOe_n[1:0]}, eb);
    check("audio lines", {padLine[3:2], lineOe_n[3:2]}, ea);
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    int k;
    int n;
    int base;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check("run", dspClockRun, 1'b1);
    for (k = 0; k < 4; k++) begin
      regRead(k);
      check("reset", rdata, mdl[k]);
    end
    lineCheck();
    for (k = 3; k >= 0; k--) begin
      seed = lfsrNext(seed);
      regWrite(k, (k != 0) ? seed[7:0] : {5'h16, seed[2:0]});
      regRead(k);
      check("readback", rdata, mdl[k]);
    end
    apb(1'b1, 16'h8010, 8'h5a, 4'h0);
    regRead(2);
    check("no strobe", rdata, mdl[2]);
    apb(1'b0, 16'h8018, 8'h00, 4'h0);
    check("unmapped err", lastErr, 1'b1);
    check("unmapped data", rdata, 32'h0);
    regWrite(0, 8'h30);
    check("run off", dspClockRun, 1'b0);
    irqPulse();
    regWrite(0, 8'h10);
    repeat (2) @(posedge clk);
    check("high z", {highZ, clkOe_n, lineOe_n}, 6'h3f);
    irqPulse();
    check("float only", {highZ, clkOe_n}, 2'h1);
    for (k = 0; k < 2; k++) begin
      seed = lfsrNext(seed);
      n = (k != 0) ? seed[3:0] : 258;
      regWrite(1, n[15:8]);
      regWrite(2, n[7:0]);
      regWrite(0, 8'ha0);
      base = pinEdges;
      for (int t = 0; t < 2000 && pinEdges < base + 3; t++) @(posedge clk);
      if (pinEdges < base + 3) begin
        fail_count++;
        tally_and_finish();
      end
      check("half period", halfPeriod, n + 1);
    end
    for (k = 0; k < 2; k++) begin
      regWrite(0, (k != 0) ? 8'he8 : 8'ha8);
      repeat (40) @(posedge clk);
      base = strobes;
      repeat (80) @(posedge clk);
      check("strobes", strobes - base, (k != 0) ? 10 : 5);
    end
    lineCheck();
    tally_and_finish();
  end
endmodule
